/* File: design/osc_pkg.sv */
package osc_pkg;

  // clock rate of the register side
  localparam int CLK_FREQ_KHZ = 25000;
  // settle time after leaving the low-frequency source, in microseconds
  localparam int SETTLE_TIME_US = 4000;
  localparam int SETTLE_CYCLES = SETTLE_TIME_US * CLK_FREQ_KHZ / 1000;
  // falling edges of the requested clock before the handover
  localparam int HANDOVER_EDGES = 8;

  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 8;
  localparam int FSEL_WIDTH = 3;
  localparam int MODE_WIDTH = 3;
  localparam int IRQ_WIDTH = 2;
  localparam int POSTSCALE_WIDTH = 6;
  localparam int FOSC_DIV_WIDTH = 2;

  // register byte addresses
  localparam logic [7:0] REG_OSC_CONTROL = 8'h00;
  localparam logic [7:0] REG_OSC_MODE = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_CLEAR = 8'h0C;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h10;

  // oscillator control field positions
  localparam int FSEL_LSB = 4;
  localparam int FSEL_MSB = 6;
  localparam int SWITCHING_BIT = 3;
  localparam int STABLE_BIT = 2;

  // interrupt event bits
  localparam int IRQ_SWITCH_DONE = 0;
  localparam int IRQ_STABLE = 1;

  // frequency select codes
  localparam logic [2:0] FSEL_LF_RC = 3'h0;
  localparam logic [2:0] FSEL_8MHZ = 3'h7;
  localparam logic [2:0] FSEL_RESET = 3'h0;

  // oscillator modes, one per three-bit code
  typedef enum logic [2:0] {
    crystal_low_power_mode = 3'h0,
    crystal_resonator_mode = 3'h1,
    crystal_high_speed_mode = 3'h2,
    external_clock_pin_free_mode = 3'h3,
    internal_osc_pins_free_mode = 3'h4,
    internal_osc_clock_out_mode = 3'h5,
    ext_res_cap_pin_free_mode = 3'h6,
    ext_res_cap_clock_out_mode = 3'h7
  } osc_mode_type;

  localparam osc_mode_type MODE_RESET = internal_osc_pins_free_mode;

endpackage : osc_pkg

/* File: design/switch_if.sv */
// handover and settle handshakes between the switch control and its counters
interface switch_if;
  logic start_count;
  logic new_fall;
  logic count_done;
  logic start_settle;
  logic settle_busy;
  logic settle_done;

  modport control (output start_count, output new_fall, output start_settle,
    input count_done, input settle_busy, input settle_done);
  modport counter (input start_count, input new_fall, output count_done);
  modport timer (input start_settle, output settle_busy, output settle_done);
endinterface : switch_if

/* File: design/handover_counter.sv */
module handover_counter
  import osc_pkg::*;
#(
  parameter int EDGES = HANDOVER_EDGES
) (
  input wire logic clk,
  input wire logic reset,
  switch_if.counter sw
);

  localparam int CW = $clog2(EDGES + 1);
  localparam logic [CW-1:0] LAST = CW'(EDGES - 1);
  // parked one past the last fall, so the done pulse fires once per start
  localparam logic [CW-1:0] IDLE = CW'(EDGES);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  int falls_seen;

  // counts falling edges of the requested clock since the last start_count, raised at the old clock's fall or a retarget
  always_comb begin
    next_count = count;
    if (sw.start_count) begin
      next_count = '0;
    end else if (sw.new_fall && count != IDLE) begin
      next_count = count + CW'(1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= IDLE;
    end else begin
      count <= next_count;
    end
  end

  // the eighth fall ends the wait
  assign sw.count_done = sw.new_fall && count == LAST && !sw.start_count;

  // helper: falls seen since the last start
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      falls_seen <= 0;
    end else if (sw.start_count) begin
      falls_seen <= 0;
    end else if (sw.new_fall) begin
      falls_seen <= falls_seen + 1;
    end
  end

  property p_eight_falls;
    @(posedge clk) disable iff (reset)
      sw.count_done |-> falls_seen == EDGES - 1;
  endproperty
  a_eight_falls: assert property (p_eight_falls)
    else $error("handover did not wait for eight falling edges");

endmodule : handover_counter

/* File: design/settle_timer.sv */
module settle_timer
  import osc_pkg::*;
#(
  parameter int CYCLES = SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  switch_if.timer sw
);

  localparam int TW = $clog2(CYCLES + 1);

  logic [TW-1:0] remain;
  logic [TW-1:0] next_remain;
  int elapsed;

  // a new start reloads the full delay, so back-to-back exits restart it
  always_comb begin
    next_remain = remain;
    if (sw.start_settle) begin
      next_remain = TW'(CYCLES);
    end else if (remain != '0) begin
      next_remain = remain - TW'(1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      remain <= '0;
    end else begin
      remain <= next_remain;
    end
  end

  assign sw.settle_busy = remain != '0;
  assign sw.settle_done = remain == TW'(1) && !sw.start_settle;

  // helper: cycles since the last start
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      elapsed <= 0;
    end else if (sw.start_settle) begin
      elapsed <= 1;
    end else if (remain != '0) begin
      elapsed <= elapsed + 1;
    end
  end

  property p_settle_length;
    @(posedge clk) disable iff (reset)
      sw.settle_done |-> elapsed == CYCLES;
  endproperty
  a_settle_length: assert property (p_settle_length)
    else $error("settle delay has the wrong length");

endmodule : settle_timer

/* File: design/osc_switch.sv */
// Summary of operation
// - eight oscillator modes are chosen by a three-bit mode field.
// - external RC mode drives clock/4 on port A bit six; pin-free modes release it.
// - internal clock-out mode drives clock/4 on bit six; pins-free mode frees both.
// - frequency select picks low-frequency RC, 8 MHz, or six postscaled rates.
// - writing the frequency select changes the chosen frequency at once.
// - the frequency select may be written whatever source runs the clock.
// - leaving code 000 for another code starts a delay of about 4 ms.
// - the stable flag stays clear during that delay.
// - switching between two nonzero codes has no delay and keeps the flag set.
// - a switch waits for a falling edge of the old clock, then holds output low.
// - after eight falling edges of the new clock the output takes the new source.
// - a switch down to code 000 ends after the handover with no delay.
// - code keeps running on the new clock while it settles.
//
// The register addresses and strobed register access were left to the implementer.
module osc_switch
  import osc_pkg::*;
#(
  parameter int SETTLE_COUNT = SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_WIDTH-1:0] addr,
  input wire logic [DATA_WIDTH-1:0] wdata,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [DATA_WIDTH-1:0] rdata,
  input wire logic low_freq_rc_source,
  input wire logic main_internal_8mhz_source,
  output logic sys_clock_out,
  input wire logic port_a_bit_six_gpio_out,
  input wire logic port_a_bit_six_gpio_oe_n,
  input wire logic port_a_bit_seven_gpio_out,
  input wire logic port_a_bit_seven_gpio_oe_n,
  output logic port_a_bit_six_out,
  output logic port_a_bit_six_oe_n,
  output logic port_a_bit_seven_out,
  output logic port_a_bit_seven_oe_n,
  output logic irq
);

  typedef enum logic [2:0] {
    st_run = 3'b001,
    st_wait_old_fall = 3'b010,
    st_count_new = 3'b100
  } switch_state_type;

  switch_if sw ();

  // two flip-flop synchronisers for the free-running sources
  logic [1:0] lf_sync;
  logic [1:0] hf_sync;
  logic hf_prev;
  logic [POSTSCALE_WIDTH-1:0] postscale;
  logic [POSTSCALE_WIDTH-1:0] next_postscale;
  logic [2**FSEL_WIDTH-1:0] level_now;
  logic [2**FSEL_WIDTH-1:0] level_prev;

  // register state
  logic [FSEL_WIDTH-1:0] internal_freq_select;
  osc_mode_type oscillator_mode_config;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] irq_enable;
  logic freq_stable_flag;
  logic [FSEL_WIDTH-1:0] next_freq_select;
  osc_mode_type next_mode;
  logic [IRQ_WIDTH-1:0] next_irq_status;
  logic [IRQ_WIDTH-1:0] next_irq_enable;
  logic next_stable;
  logic [DATA_WIDTH-1:0] next_rdata;

  // switch state
  switch_state_type state;
  switch_state_type next_state;
  logic [FSEL_WIDTH-1:0] cur_code;
  logic [FSEL_WIDTH-1:0] target_code;
  logic [FSEL_WIDTH-1:0] next_cur_code;
  logic [FSEL_WIDTH-1:0] next_target_code;
  logic next_clock_out;
  logic [FOSC_DIV_WIDTH-1:0] fosc_div;
  logic [FOSC_DIV_WIDTH-1:0] next_fosc_div;
  logic fosc_div4;
  logic old_fall;
  logic switch_done;
  logic leave_lf;

  // an address decoder shared by the write and read paths
  function automatic logic hit(input logic [ADDR_WIDTH-1:0] a, input logic [7:0] reg_addr);
    hit = a == reg_addr;
  endfunction : hit

  // postscaler tap for a nonzero code: 111 is the raw 8 MHz, 001 the slowest
  function automatic logic pick_level(input logic [FSEL_WIDTH-1:0] code,
      input logic lf, input logic hf, input logic [POSTSCALE_WIDTH-1:0] ps);
    if (code == FSEL_LF_RC) begin
      pick_level = lf;
    end else if (code == FSEL_8MHZ) begin
      pick_level = hf;
    end else begin
      pick_level = ps[FSEL_8MHZ - code - FSEL_WIDTH'(1)];
    end
  endfunction : pick_level

  // source synchronisers; only the second stage feeds logic
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lf_sync <= '0;
      hf_sync <= '0;
      hf_prev <= 1'b0;
    end else begin
      lf_sync <= {lf_sync[0], low_freq_rc_source};
      hf_sync <= {hf_sync[0], main_internal_8mhz_source};
      hf_prev <= hf_sync[1];
    end
  end

  // postscaler divides the 8 MHz source by 2 to 64
  always_comb begin
    next_postscale = postscale;
    if (hf_sync[1] && !hf_prev) begin
      next_postscale = postscale + POSTSCALE_WIDTH'(1);
    end
  end

  // one level per code, so any code's falling edge can be seen
  genvar g;
  generate
    for (g = 0; g < 2**FSEL_WIDTH; g++) begin : g_level
      assign level_now[g] = pick_level(FSEL_WIDTH'(g), lf_sync[1], hf_sync[1], postscale);
    end
  endgenerate

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      postscale <= '0;
      level_prev <= '0;
    end else begin
      postscale <= next_postscale;
      level_prev <= level_now;
    end
  end

  assign old_fall = level_prev[cur_code] && !level_now[cur_code];
  assign sw.new_fall = level_prev[target_code] && !level_now[target_code];

  // glitch-free switch: wait for old fall, hold low, count new falls
  always_comb begin
    next_state = state;
    next_cur_code = cur_code;
    next_target_code = target_code;
    next_clock_out = level_now[cur_code];
    sw.start_count = 1'b0;
    switch_done = 1'b0;
    unique case (state)
      st_run: begin
        if (internal_freq_select != cur_code) begin
          next_target_code = internal_freq_select;
          next_state = st_wait_old_fall;
        end
      end
      st_wait_old_fall: begin
        next_target_code = internal_freq_select;
        if (old_fall) begin
          next_clock_out = 1'b0;
          sw.start_count = 1'b1;
          next_state = st_count_new;
        end
      end
      st_count_new: begin
        next_clock_out = 1'b0;
        if (internal_freq_select != target_code) begin
          // a late write restarts the count on the newest request
          next_target_code = internal_freq_select;
          sw.start_count = 1'b1;
        end else if (sw.count_done) begin
          next_cur_code = target_code;
          next_clock_out = level_now[target_code];
          switch_done = 1'b1;
          next_state = st_run;
        end
      end
    endcase
  end

  // only an exit from the low-frequency source needs the settle delay
  assign leave_lf = switch_done && cur_code == FSEL_LF_RC && target_code != FSEL_LF_RC;
  assign sw.start_settle = leave_lf;

  // system clock divided by four, advanced on each output falling edge
  always_comb begin
    next_fosc_div = fosc_div;
    if (sys_clock_out && !next_clock_out) begin
      next_fosc_div = fosc_div + FOSC_DIV_WIDTH'(1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= st_run;
      cur_code <= FSEL_RESET;
      target_code <= FSEL_RESET;
      sys_clock_out <= 1'b0;
      fosc_div <= '0;
    end else begin
      state <= next_state;
      cur_code <= next_cur_code;
      target_code <= next_target_code;
      sys_clock_out <= next_clock_out;
      fosc_div <= next_fosc_div;
    end
  end

  assign fosc_div4 = fosc_div[FOSC_DIV_WIDTH-1];

  // pin use follows the oscillator mode; crystal modes leave both pins to the oscillator
  always_comb begin
    port_a_bit_six_out = 1'b0;
    port_a_bit_six_oe_n = 1'b1;
    port_a_bit_seven_out = 1'b0;
    port_a_bit_seven_oe_n = 1'b1;
    unique case (oscillator_mode_config)
      ext_res_cap_clock_out_mode: begin
        port_a_bit_six_out = fosc_div4;
        port_a_bit_six_oe_n = 1'b0;
      end
      ext_res_cap_pin_free_mode, external_clock_pin_free_mode: begin
        port_a_bit_six_out = port_a_bit_six_gpio_out;
        port_a_bit_six_oe_n = port_a_bit_six_gpio_oe_n;
      end
      internal_osc_clock_out_mode: begin
        port_a_bit_six_out = fosc_div4;
        port_a_bit_six_oe_n = 1'b0;
        port_a_bit_seven_out = port_a_bit_seven_gpio_out;
        port_a_bit_seven_oe_n = port_a_bit_seven_gpio_oe_n;
      end
      internal_osc_pins_free_mode: begin
        port_a_bit_six_out = port_a_bit_six_gpio_out;
        port_a_bit_six_oe_n = port_a_bit_six_gpio_oe_n;
        port_a_bit_seven_out = port_a_bit_seven_gpio_out;
        port_a_bit_seven_oe_n = port_a_bit_seven_gpio_oe_n;
      end
      crystal_low_power_mode, crystal_resonator_mode, crystal_high_speed_mode: begin
      end
    endcase
  end

  // register writes, stable flag and sticky events; a set beats a clear
  always_comb begin
    next_freq_select = internal_freq_select;
    next_mode = oscillator_mode_config;
    next_irq_enable = irq_enable;
    next_irq_status = irq_status;
    next_stable = freq_stable_flag;
    next_rdata = '0;
    if (write_strobe && hit(addr, REG_OSC_CONTROL)) begin
      next_freq_select = wdata[FSEL_MSB:FSEL_LSB];
    end
    if (write_strobe && hit(addr, REG_OSC_MODE)) begin
      next_mode = osc_mode_type'(wdata[MODE_WIDTH-1:0]);
    end
    if (write_strobe && hit(addr, REG_IRQ_ENABLE)) begin
      next_irq_enable = wdata[IRQ_WIDTH-1:0];
    end
    if (write_strobe && hit(addr, REG_IRQ_CLEAR)) begin
      next_irq_status = irq_status & ~wdata[IRQ_WIDTH-1:0];
    end
    if (state == st_wait_old_fall && cur_code == FSEL_LF_RC) begin
      next_stable = 1'b0;
    end
    if (sw.settle_done) begin
      next_stable = 1'b1;
      next_irq_status[IRQ_STABLE] = 1'b1;
    end
    if (switch_done) begin
      next_irq_status[IRQ_SWITCH_DONE] = 1'b1;
    end
    if (read_strobe) begin
      if (hit(addr, REG_OSC_CONTROL)) begin
        next_rdata[FSEL_MSB:FSEL_LSB] = internal_freq_select;
        next_rdata[SWITCHING_BIT] = state != st_run;
        next_rdata[STABLE_BIT] = freq_stable_flag;
      end else if (hit(addr, REG_OSC_MODE)) begin
        next_rdata[MODE_WIDTH-1:0] = oscillator_mode_config;
      end else if (hit(addr, REG_IRQ_STATUS)) begin
        next_rdata[IRQ_WIDTH-1:0] = irq_status;
      end else if (hit(addr, REG_IRQ_ENABLE)) begin
        next_rdata[IRQ_WIDTH-1:0] = irq_enable;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      internal_freq_select <= FSEL_RESET;
      oscillator_mode_config <= MODE_RESET;
      irq_enable <= '0;
      irq_status <= '0;
      freq_stable_flag <= 1'b0;
      rdata <= '0;
    end else begin
      internal_freq_select <= next_freq_select;
      oscillator_mode_config <= next_mode;
      irq_enable <= next_irq_enable;
      irq_status <= next_irq_status;
      freq_stable_flag <= next_stable;
      rdata <= next_rdata;
    end
  end

  assign irq = |(irq_status & irq_enable);

  handover_counter #(.EDGES(HANDOVER_EDGES)) u_counter (.clk(clk), .reset(reset), .sw(sw));
  settle_timer #(.CYCLES(SETTLE_COUNT)) u_timer (.clk(clk), .reset(reset), .sw(sw));

  property p_hold_low;
    @(posedge clk) disable iff (reset)
      state == st_count_new |=> !sys_clock_out || state == st_run;
  endproperty
  a_hold_low: assert property (p_hold_low)
    else $error("clock output not held low during handover");

  property p_write_immediate;
    @(posedge clk) disable iff (reset)
      write_strobe && addr == REG_OSC_CONTROL |=>
        internal_freq_select == $past(wdata[FSEL_MSB:FSEL_LSB]);
  endproperty
  a_write_immediate: assert property (p_write_immediate)
    else $error("frequency select did not take the written value");

  property p_exit_starts_settle;
    @(posedge clk) disable iff (reset)
      switch_done && cur_code == FSEL_LF_RC && target_code != FSEL_LF_RC |=> sw.settle_busy;
  endproperty
  a_exit_starts_settle: assert property (p_exit_starts_settle)
    else $error("settle delay not started after leaving low-frequency source");

  property p_unstable_while_settling;
    @(posedge clk) disable iff (reset)
      sw.settle_busy && !sw.settle_done |-> !freq_stable_flag;
  endproperty
  a_unstable_while_settling: assert property (p_unstable_while_settling)
    else $error("stable flag set during settle delay");

  property p_stable_after_settle;
    @(posedge clk) disable iff (reset)
      sw.settle_done |=> freq_stable_flag ##1 freq_stable_flag;
  endproperty
  a_stable_after_settle: assert property (p_stable_after_settle)
    else $error("stable flag not set when settle delay ended");

  property p_nonzero_keeps_flag;
    @(posedge clk) disable iff (reset)
      state == st_wait_old_fall && cur_code != FSEL_LF_RC && freq_stable_flag
        |=> freq_stable_flag && !sw.settle_busy;
  endproperty
  a_nonzero_keeps_flag: assert property (p_nonzero_keeps_flag)
    else $error("switch between nonzero codes disturbed the stable flag");

  property p_down_no_delay;
    @(posedge clk) disable iff (reset)
      switch_done && target_code == FSEL_LF_RC |=> !sw.settle_busy;
  endproperty
  a_down_no_delay: assert property (p_down_no_delay)
    else $error("switch to low-frequency source started a delay");

  property p_rc_clock_out;
    @(posedge clk) disable iff (reset)
      oscillator_mode_config == ext_res_cap_clock_out_mode |->
        !port_a_bit_six_oe_n && port_a_bit_six_out == fosc_div[FOSC_DIV_WIDTH-1];
  endproperty
  a_rc_clock_out: assert property (p_rc_clock_out)
    else $error("clock/4 missing on port A bit six");

  property p_int_pins_free;
    @(posedge clk) disable iff (reset)
      oscillator_mode_config == internal_osc_pins_free_mode |->
        port_a_bit_six_oe_n == port_a_bit_six_gpio_oe_n &&
        port_a_bit_seven_oe_n == port_a_bit_seven_gpio_oe_n;
  endproperty
  a_int_pins_free: assert property (p_int_pins_free)
    else $error("internal pins-free mode did not release both pins");

endmodule : osc_switch

/* File: testbench/osc_switch_tb.sv */
module osc_switch_tb
  import osc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // short settle so the run stays brief
  localparam int SETTLE = 50;
  typedef struct packed {
    logic [2:0] mode;
    logic six_oe_n;
    logic seven_oe_n;
  } pin_row_type;
  logic clk, reset, write_strobe, read_strobe, sys_clock_out, irq;
  logic lf_src = 1'b0;
  logic hf_src = 1'b0;
  logic [ADDR_WIDTH-1:0] addr;
  logic [DATA_WIDTH-1:0] wdata, rdata, v;
  logic six_out, six_oe_n, seven_out, seven_oe_n, clr_max, prev_six, prev_clk, gpio_out;
  int mismatches, checked, polls, toggles, falls;
  int div_cnt = 0;
  int low_run = 0;
  int max_low = 0;
  pin_row_type rows [8];

  osc_switch #(.SETTLE_COUNT(SETTLE)) i_osc_switch (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .rdata(rdata),
    .low_freq_rc_source(lf_src), .main_internal_8mhz_source(hf_src),
    .sys_clock_out(sys_clock_out),
    .port_a_bit_six_gpio_out(gpio_out), .port_a_bit_six_gpio_oe_n(1'b0),
    .port_a_bit_seven_gpio_out(gpio_out), .port_a_bit_seven_gpio_oe_n(1'b0),
    .port_a_bit_six_out(six_out), .port_a_bit_six_oe_n(six_oe_n),
    .port_a_bit_seven_out(seven_out), .port_a_bit_seven_oe_n(seven_oe_n),
    .irq(irq));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // sources: fast one at a quarter of clk, slow one at a sixteenth
  always @(posedge clk) begin
    div_cnt <= div_cnt + 1;
    if (div_cnt % 2 == 1) hf_src <= ~hf_src;
    if (div_cnt % 8 == 7) lf_src <= ~lf_src;
  end

  // longest low stretch of the output clock, reveals the handover gap
  always @(posedge clk) begin
    low_run <= sys_clock_out ? 0 : low_run + 1;
    if (clr_max) max_low <= 0;
    else if (low_run > max_low) max_low <= low_run;
  end

  task automatic fail_msg(input string msg);
    mismatches++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask : fail_msg

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) fail_msg(what);
  endtask : check_byte

  task automatic check_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) fail_msg(what);
  endtask : check_bit

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    write_strobe <= 1'b1;
    @(posedge clk);
    write_strobe <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    read_strobe <= 1'b1;
    @(posedge clk);
    read_strobe <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_read

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cycles

  // poll until the switching bit drops; optionally the stable flag must hold
  task automatic wait_idle(input bit watch);
    polls = 0;
    do begin
      reg_read(REG_OSC_CONTROL, v);
      polls++;
      if (watch) check_bit(v[STABLE_BIT], 1'b1, "stable dropped");
    end while (v[SWITCHING_BIT] !== 1'b0 && polls < 2000);
    if (polls >= 2000) begin
      fail_msg("switch hang");
      complete_run();
    end
  endtask : wait_idle

  task automatic complete_run();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  initial begin
    rows = '{'{3'h0, 1'b1, 1'b1}, '{3'h1, 1'b1, 1'b1}, '{3'h2, 1'b1, 1'b1},
      '{3'h3, 1'b0, 1'b1}, '{3'h4, 1'b0, 1'b0}, '{3'h5, 1'b0, 1'b0},
      '{3'h6, 1'b0, 1'b1}, '{3'h7, 1'b0, 1'b1}};
    {write_strobe, read_strobe, gpio_out, clr_max} = 4'h0;
    addr = 8'h00;
    wdata = 8'h00;
    mismatches = 0;
    checked = 0;
    reset = 1'b1;
    wait_cycles(10);
    reset <= 1'b0;
    // reset values
    reg_read(REG_OSC_CONTROL, v);
    check_byte(v, 8'h00, "control reset");
    reg_read(REG_OSC_MODE, v);
    check_byte(v, 8'h04, "mode reset");
    check_bit(irq, 1'b0, "irq reset");
    // every oscillator mode: readback and pin ownership
    foreach (rows[i]) begin
      // vary the port drive so a pass-through is told apart from a stuck level
      @(posedge clk);
      gpio_out <= 1'(i);
      reg_write(REG_OSC_MODE, {5'h00, rows[i].mode});
      reg_read(REG_OSC_MODE, v);
      check_byte(v, {5'h00, rows[i].mode}, "mode readback");
      check_bit(six_oe_n, rows[i].six_oe_n, "bit six enable");
      check_bit(seven_oe_n, rows[i].seven_oe_n, "bit seven enable");
      if (rows[i].mode == 3'h5 || rows[i].mode == 3'h7) begin
        toggles = 0;
        falls = 0;
        prev_six = six_out;
        prev_clk = sys_clock_out;
        repeat (400) begin
          @(posedge clk);
          #1;
          if (six_out !== prev_six) toggles++;
          if (prev_clk && !sys_clock_out) falls++;
          prev_six = six_out;
          prev_clk = sys_clock_out;
        end
        check_bit(toggles > 2 && (toggles * 2 - falls) inside {[-3:3]}, 1'b1,
          "clock/4 output");
      end else if (!rows[i].six_oe_n) begin
        check_bit(six_out, 1'(i), "bit six gpio");
      end
      if (!rows[i].seven_oe_n) check_bit(seven_out, 1'(i), "bit seven gpio");
    end
    // low-frequency source to 8 MHz with settle delay
    reg_write(REG_IRQ_ENABLE, 8'h03);
    reg_read(REG_IRQ_ENABLE, v);
    check_byte(v, 8'h03, "enable readback");
    clr_max <= 1'b1;
    reg_write(REG_OSC_CONTROL, 8'h70);
    clr_max <= 1'b0;
    reg_read(REG_OSC_CONTROL, v);
    check_byte(v[6:4], 8'h07, "select not immediate");
    wait_idle(1'b0);
    check_bit(max_low >= 24, 1'b1, "no low handover gap");
    reg_read(REG_IRQ_STATUS, v);
    check_byte(v, 8'h01, "switch done event");
    check_bit(irq, 1'b1, "irq not raised");
    // the low-stretch monitor restarts here; a stalled clock would show a long run
    clr_max <= 1'b1;
    polls = 0;
    do begin
      reg_read(REG_OSC_CONTROL, v);
      clr_max <= 1'b0;
      polls++;
    end while (v[STABLE_BIT] !== 1'b1 && polls < 200);
    check_bit(polls * 2 >= SETTLE - 6 && polls * 2 <= SETTLE + 10, 1'b1,
      "settle length");
    check_bit(max_low < 8, 1'b1, "clock stopped in settle");
    wait_cycles(3 * SETTLE);
    reg_read(REG_OSC_CONTROL, v);
    check_byte(v, 8'h74, "stable not held");
    reg_read(REG_IRQ_STATUS, v);
    check_byte(v, 8'h03, "stable event");
    // clear, mask, read-only and unmapped places
    reg_write(REG_IRQ_CLEAR, 8'h01);
    reg_read(REG_IRQ_STATUS, v);
    check_byte(v, 8'h02, "partial clear");
    check_bit(irq, 1'b1, "irq lost");
    reg_write(REG_IRQ_ENABLE, 8'h01);
    wait_cycles(1);
    check_bit(irq, 1'b0, "mask ignored");
    reg_write(REG_IRQ_CLEAR, 8'h02);
    reg_write(REG_IRQ_STATUS, 8'hFF);
    reg_read(REG_IRQ_STATUS, v);
    check_byte(v, 8'h00, "status writable");
    reg_read(8'hFC, v);
    check_byte(v, 8'h00, "unmapped read");
    // nonzero to nonzero, retargeted back to back: no delay, flag kept
    reg_write(REG_OSC_CONTROL, 8'h30);
    reg_write(REG_OSC_CONTROL, 8'h50);
    wait_idle(1'b1);
    wait_cycles(SETTLE + 10);
    reg_read(REG_OSC_CONTROL, v);
    check_byte(v, 8'h54, "retarget");
    reg_read(REG_IRQ_STATUS, v);
    check_byte(v, 8'h01, "unexpected settle");
    check_bit(irq, 1'b1, "done irq");
    reg_write(REG_IRQ_CLEAR, 8'h03);
    // down to the low-frequency source: handover only
    reg_write(REG_OSC_CONTROL, 8'h00);
    wait_idle(1'b0);
    wait_cycles(SETTLE + 10);
    reg_read(REG_IRQ_STATUS, v);
    check_byte(v, 8'h01, "delay on way down");
    reg_read(REG_OSC_CONTROL, v);
    check_byte(v, 8'h04, "control after down");
    // reset in mid-run
    @(posedge clk);
    reset <= 1'b1;
    wait_cycles(3);
    reset <= 1'b0;
    reg_read(REG_OSC_CONTROL, v);
    check_byte(v, 8'h00, "control second reset");
    reg_read(REG_OSC_MODE, v);
    check_byte(v, 8'h04, "mode second reset");
    check_bit(irq, 1'b0, "irq second reset");
    complete_run();
  end
endmodule : osc_switch_tb
